//--- cbb_exec.sv
// Decode and execute unit for compare-with-borrow and the compare-and-branch group.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Compare-with-borrow updates flags, stores no difference.
// - Decode compare-with-borrow from its opcode pattern.
// - Base register direct; source direct or indirect.
// - Width bit: clear word, set byte.
// - Zero flag sticky: may clear, never set.
// - Branch-equal taken only on equal operands.
// - Branch-greater taken when base signed greater.
// - Branch-less taken when base signed less.
// - Taken: flush prefetch, load target, issue no-op.
// - Offset six-bit signed, sign-extended, counts words.
// - Fields w, s, n pick base, second, offset.
// - Not taken: next instruction runs, no flush.
// - Compare-branches store nothing, keep all flags.
// - One word; one cycle, five when taken.
module cbb_exec
	import cbb_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 nrst,
	input  wire logic                 clock_en,
	input  wire logic                 instr_valid,
	input  wire logic [INSTR_W-1:0]   instr_word,
	input  wire logic [DATA_W-1:0]    instr_addr,
	input  wire logic [DATA_W-1:0]    base_operand_reg,
	input  wire logic [DATA_W-1:0]    source_operand_reg,
	input  wire logic [DATA_W-1:0]    second_operand_reg,
	input  wire logic [DATA_W-1:0]    src_pointer,
	input  wire logic [ADDR_W-1:0]    reg_addr,
	input  wire logic [DATA_W-1:0]    reg_wdata,
	input  wire logic                 reg_write,
	input  wire logic                 reg_read,
	output logic      [DATA_W-1:0]    reg_rdata,
	output logic      [DATA_W-1:0]    status_word,
	output logic                      busy,
	output logic                      claimed,
	output logic                      pc_load,
	output logic      [DATA_W-1:0]    pc_target,
	output logic                      flush_prefetch,
	output logic                      nop_issue,
	output var cbb_ptr_wb_s           ptr_wb
);

	cbb_decode_s       dec;
	cbb_flags_s        flags;
	cbb_flags_s        next_flags;
	logic              accept;
	logic              is_branch;
	logic              branch_cond;
	logic              take_branch;
	logic [2:0]        stall_count;
	logic [DATA_W-1:0] last_target;
	logic [DATA_W-1:0] next_target;
	logic [DATA_W-1:0] offset_ext;
	logic [DATA_W-1:0] next_pointer;
	logic              ptr_changes;

	// Operand views after width selection.
	logic [DATA_W-1:0] cmp_a;
	logic [DATA_W-1:0] cmp_b;
	logic              sign_a;
	logic              sign_b;
	logic [DATA_W:0]   diff;
	logic              diff_zero;
	logic              diff_sign;
	logic              carry_out;
	logic              digit_carry;
	logic [4:0]        nibble_sum;
	logic [8:0]        low_byte_sum;

	// Instructions are only taken once the stall of a taken branch has drained.
	assign accept = clock_en & instr_valid & (stall_count == 3'h0);

	// Field extraction and opcode match.
	always_comb begin
		dec.base_sel  = instr_word[14:11];
		dec.byte_mode = instr_word[10];
		dec.src_mode  = instr_word[6:4];
		dec.offset    = instr_word[9:4];
		dec.src_sel   = instr_word[3:0];
		case (instr_word[23:15])
			OPC_COMPARE_WITH_BORROW: begin
				if (instr_word[9:7] == BORROW_FIXED_ZERO) begin
					dec.op = CBB_OP_BORROW;
				end else begin
					dec.op = CBB_OP_NONE;
				end
			end
			OPC_BRANCH_EQUAL: begin
				dec.op = CBB_OP_BEQ;
			end
			OPC_BRANCH_GREATER: begin
				dec.op = CBB_OP_BGT;
			end
			OPC_BRANCH_LESS: begin
				dec.op = CBB_OP_BLT;
			end
			default: begin
				dec.op = CBB_OP_NONE;
			end
		endcase
	end

	// The borrow compare subtracts the source operand, the branches the second register.
	always_comb begin
		cmp_a = base_operand_reg;
		if (dec.op == CBB_OP_BORROW) begin
			cmp_b = source_operand_reg;
		end else begin
			cmp_b = second_operand_reg;
		end
		if (dec.byte_mode) begin
			cmp_a = {8'h00, base_operand_reg[7:0]};
			cmp_b = {8'h00, cmp_b[7:0]};
		end
	end

	// Subtraction as a + ~b + carry, so the carry out means no borrow.
	always_comb begin
		if (dec.op == CBB_OP_BORROW) begin
			diff = {1'b0, cmp_a} + {1'b0, ~cmp_b} + {16'h0000, flags.carry};
		end else begin
			diff = {1'b0, cmp_a} + {1'b0, ~cmp_b} + 17'h00001;
		end
		nibble_sum   = {1'b0, cmp_a[3:0]} + {1'b0, ~cmp_b[3:0]} + {4'h0, flags.carry};
		low_byte_sum = {1'b0, cmp_a[7:0]} + {1'b0, ~cmp_b[7:0]} + {8'h00, flags.carry};
		if (dec.byte_mode) begin
			diff_zero   = (diff[7:0] == 8'h00);
			diff_sign   = diff[7];
			carry_out   = low_byte_sum[8];
			digit_carry = nibble_sum[4];
			sign_a      = cmp_a[7];
			sign_b      = cmp_b[7];
		end else begin
			diff_zero   = (diff[15:0] == 16'h0000);
			diff_sign   = diff[15];
			carry_out   = diff[16];
			digit_carry = low_byte_sum[8];
			sign_a      = cmp_a[15];
			sign_b      = cmp_b[15];
		end
	end

	// Flag results of the borrow compare.
	always_comb begin
		next_flags = flags;
		if (dec.op == CBB_OP_BORROW) begin
			next_flags.carry            = carry_out;
			next_flags.digit_carry_flag = digit_carry;
			next_flags.negative         = diff_sign;
			// Signed overflow: operands of unlike sign and a result sign unlike the base.
			next_flags.overflow_flag    = (sign_a ^ sign_b) & (diff_sign ^ sign_a);
			// Zero can only fall; a zero result keeps whatever was there before.
			next_flags.zero             = flags.zero & diff_zero;
		end
	end

	// Branch conditions work on the width-selected operands.
	always_comb begin
		is_branch = 1'b0;
		branch_cond = 1'b0;
		case (dec.op)
			CBB_OP_BEQ: begin
				is_branch   = 1'b1;
				branch_cond = (cmp_a == cmp_b);
			end
			CBB_OP_BGT: begin
				is_branch = 1'b1;
				if (sign_a != sign_b) begin
					branch_cond = sign_b;
				end else begin
					branch_cond = (cmp_a > cmp_b);
				end
			end
			CBB_OP_BLT: begin
				is_branch = 1'b1;
				if (sign_a != sign_b) begin
					branch_cond = sign_a;
				end else begin
					branch_cond = (cmp_a < cmp_b);
				end
			end
			default: begin
				is_branch   = 1'b0;
				branch_cond = 1'b0;
			end
		endcase
	end

	assign take_branch = accept & is_branch & branch_cond;

	// Target is the word after the branch plus the sign-extended offset in words.
	always_comb begin
		offset_ext  = {{(DATA_W-6){dec.offset[5]}}, dec.offset};
		next_target = instr_addr + NEXT_WORD + (offset_ext << OFFSET_SHIFT);
	end

	// Pointer writeback for the post and pre modifying source modes; steps follow operand width.
	always_comb begin
		next_pointer = src_pointer;
		ptr_changes  = 1'b0;
		case (dec.src_mode)
			MODE_POST_INC, MODE_PRE_INC: begin
				ptr_changes  = 1'b1;
				next_pointer = src_pointer + (dec.byte_mode ? STEP_BYTE : STEP_WORD);
			end
			MODE_POST_DEC, MODE_PRE_DEC: begin
				ptr_changes  = 1'b1;
				next_pointer = src_pointer - (dec.byte_mode ? STEP_BYTE : STEP_WORD);
			end
			MODE_DIRECT, MODE_INDIRECT: begin
				ptr_changes  = 1'b0;
				next_pointer = src_pointer;
			end
			default: begin
				ptr_changes  = 1'b0;
				next_pointer = src_pointer;
			end
		endcase
	end

	// Flag storage; a compare-with-borrow in flight wins over a software write.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			flags <= cbb_flags_s'(5'h00);
		end else if (clock_en) begin
			if (accept && dec.op == CBB_OP_BORROW) begin
				flags <= next_flags;
			end else if (reg_write && reg_addr == REG_STATUS_WORD) begin
				flags.carry            <= reg_wdata[FLAG_C_POS];
				flags.zero             <= reg_wdata[FLAG_Z_POS];
				flags.overflow_flag    <= reg_wdata[FLAG_OVERFLOW_POS];
				flags.negative         <= reg_wdata[FLAG_N_POS];
				flags.digit_carry_flag <= reg_wdata[FLAG_DIGIT_CARRY_POS];
			end
			// Compare-branches leave the flags as they were.
		end
	end

	// Status word output mirrors the flags one cycle after they change.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			status_word <= STATUS_RESET;
		end else if (clock_en) begin
			status_word                 <= STATUS_RESET;
			status_word[FLAG_C_POS]     <= flags.carry;
			status_word[FLAG_Z_POS]     <= flags.zero;
			status_word[FLAG_OVERFLOW_POS]    <= flags.overflow_flag;
			status_word[FLAG_N_POS]           <= flags.negative;
			status_word[FLAG_DIGIT_CARRY_POS] <= flags.digit_carry_flag;
		end
	end

	// Redirect, flush and no-op slot for a taken branch.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			pc_load        <= 1'b0;
			pc_target      <= TARGET_RESET;
			flush_prefetch <= 1'b0;
			nop_issue      <= 1'b0;
			last_target    <= TARGET_RESET;
		end else if (clock_en) begin
			pc_load        <= take_branch;
			flush_prefetch <= take_branch;
			nop_issue      <= take_branch;
			if (take_branch) begin
				pc_target   <= next_target;
				last_target <= next_target;
			end
		end
	end

	// A taken branch holds off new instructions for four more cycles.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			stall_count <= 3'h0;
			busy        <= 1'b0;
		end else if (clock_en) begin
			if (take_branch) begin
				stall_count <= STALL_AFTER_TAKEN;
				busy        <= 1'b1;
			end else if (stall_count != 3'h0) begin
				stall_count <= stall_count - 3'h1;
				busy        <= (stall_count != 3'h1);
			end else begin
				busy <= 1'b0;
			end
		end
	end

	// Claim pulse tells the core this block executed the word; a miss stays with the core.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			claimed <= 1'b0;
		end else if (clock_en) begin
			claimed <= accept & (dec.op != CBB_OP_NONE);
		end
	end

	// Pointer update request for post and pre modifying source modes.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ptr_wb <= '0;
		end else if (clock_en) begin
			ptr_wb.valid <= accept & (dec.op == CBB_OP_BORROW) & ptr_changes;
			if (accept && dec.op == CBB_OP_BORROW && ptr_changes) begin
				ptr_wb.sel   <= dec.src_sel;
				ptr_wb.value <= next_pointer;
			end
		end
	end

	// Read data stands in the cycle after the read strobe only.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (clock_en) begin
			reg_rdata <= 16'h0000;
			if (reg_read) begin
				case (reg_addr)
					REG_STATUS_WORD: begin
						reg_rdata[FLAG_C_POS]  <= flags.carry;
						reg_rdata[FLAG_Z_POS]  <= flags.zero;
						reg_rdata[FLAG_OVERFLOW_POS]    <= flags.overflow_flag;
						reg_rdata[FLAG_N_POS]           <= flags.negative;
						reg_rdata[FLAG_DIGIT_CARRY_POS] <= flags.digit_carry_flag;
					end
					REG_LAST_TARGET: begin
						reg_rdata <= last_target;
					end
					REG_EXEC_STATE: begin
						reg_rdata <= {13'h0000, stall_count};
					end
					default: begin
						reg_rdata <= 16'h0000;
					end
				endcase
			end
		end
	end

endmodule : cbb_exec

`default_nettype wire

//--- cbb_exec_sva.sv
// Assertion checker for the compare and compare-branch execute block.
`timescale 1ns/10ps
`default_nettype none
module cbb_exec_sva
	import cbb_pkg::*;
(
	input wire logic		clock,
	input wire logic		nrst,
	input wire logic		clock_en,
	input wire logic		instr_valid,
	input wire logic [23:0]	instr_word,
	input wire logic [15:0]	instr_addr,
	input wire logic [15:0]	base_operand_reg,
	input wire logic [15:0]	second_operand_reg,
	input wire logic		reg_write,
	input wire logic		reg_read,
	input wire logic [15:0]	reg_rdata,
	input wire logic [15:0]	status_word,
	input wire logic		busy,
	input wire logic		claimed,
	input wire logic		pc_load,
	input wire logic [15:0]	pc_target,
	input wire logic		flush_prefetch,
	input wire logic		nop_issue,
	input wire cbb_ptr_wb_s	ptr_wb
);
	logic			br;
	logic			borrow_op;
	logic			acc;
	logic			eq_w;
	logic [15:0]	tgt;
	assign br = instr_word[23:15] inside {OPC_BRANCH_EQUAL, OPC_BRANCH_GREATER, OPC_BRANCH_LESS};
	assign borrow_op = instr_word[23:15] == OPC_COMPARE_WITH_BORROW && instr_word[9:7] == 3'h0;
	// Busy covers every stall cycle; with the enable low nothing is taken at all.
	assign acc = clock_en && instr_valid && !busy;
	assign eq_w = base_operand_reg == second_operand_reg;
	assign tgt = instr_addr + 16'h0002 + {{9{instr_word[9]}}, instr_word[9:4], 1'b0};

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_taken; pc_load && flush_prefetch && nop_issue && claimed; endsequence
	sequence s_stall; busy[*4] ##1 !busy; endsequence

	property p_taken; pc_load |-> s_taken; endproperty
	a_taken: assert property (p_taken) else $error("taken branch without flush");
	property p_stall; $rose(pc_load) |-> s_stall; endproperty
	a_stall: assert property (p_stall) else $error("taken branch length wrong");
	property p_target; acc && br |=> !pc_load || pc_target == $past(tgt); endproperty
	a_target: assert property (p_target) else $error("branch target wrong");
	property p_beq;
		acc && instr_word[23:15] == OPC_BRANCH_EQUAL && !instr_word[10] |=> pc_load == $past(eq_w);
	endproperty
	a_beq: assert property (p_beq) else $error("equal branch decision wrong");
	property p_claim; acc && (br || borrow_op) |=> claimed; endproperty
	a_claim: assert property (p_claim) else $error("instruction not claimed");
	property p_keep; acc && br && !reg_write |=> ##1 $stable(status_word); endproperty
	a_keep: assert property (p_keep) else $error("branch changed status");
	property p_sticky; $rose(status_word[FLAG_Z_POS]) |-> $past(reg_write, 2); endproperty
	a_sticky: assert property (p_sticky) else $error("zero flag set by compare");
	property p_ptr;
		acc && borrow_op && instr_word[6:4] inside {[MODE_POST_DEC:MODE_PRE_INC]} |=> ptr_wb.valid;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer update missing");
	property p_idle; !reg_read |=> reg_rdata == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read cycle");
endmodule : cbb_exec_sva

bind cbb_exec cbb_exec_sva i_cbb_exec_sva (.clock, .nrst, .clock_en, .instr_valid, .instr_word,
	.instr_addr, .base_operand_reg, .second_operand_reg, .reg_write, .reg_read, .reg_rdata,
	.status_word, .busy, .claimed, .pc_load, .pc_target, .flush_prefetch, .nop_issue, .ptr_wb);
`default_nettype wire

//--- cbb_pkg.sv
// Shared constants and types of the compare and compare-branch execute block.
package cbb_pkg;

	localparam int unsigned INSTR_W   = 24;
	localparam int unsigned DATA_W    = 16;
	localparam int unsigned REG_IDX_W = 4;
	localparam int unsigned ADDR_W    = 4;

	// Opcode prefixes held in instruction bits 23:15.
	localparam logic [8:0] OPC_COMPARE_WITH_BORROW = 9'h1C3;
	localparam logic [8:0] OPC_BRANCH_EQUAL        = 9'h1CF;
	localparam logic [8:0] OPC_BRANCH_GREATER      = 9'h1CC;
	localparam logic [8:0] OPC_BRANCH_LESS         = 9'h1CD;
	// Bits 9:7 of the compare-with-borrow word must be zero.
	localparam logic [2:0] BORROW_FIXED_ZERO       = 3'h0;

	// Source addressing modes in the p field.
	localparam logic [2:0] MODE_DIRECT    = 3'h0;
	localparam logic [2:0] MODE_INDIRECT  = 3'h1;
	localparam logic [2:0] MODE_POST_DEC  = 3'h2;
	localparam logic [2:0] MODE_POST_INC  = 3'h3;
	localparam logic [2:0] MODE_PRE_DEC   = 3'h4;
	localparam logic [2:0] MODE_PRE_INC   = 3'h5;

	// Pointer steps and branch scaling.
	localparam logic [DATA_W-1:0] STEP_BYTE    = 16'h0001;
	localparam logic [DATA_W-1:0] STEP_WORD    = 16'h0002;
	localparam logic [DATA_W-1:0] NEXT_WORD    = 16'h0002;
	localparam int unsigned       OFFSET_SHIFT = 1;

	// A taken compare-branch occupies five cycles in total.
	localparam int unsigned      BRANCH_TAKEN_CYCLES = 5;
	localparam logic [2:0]       STALL_AFTER_TAKEN   = 3'(BRANCH_TAKEN_CYCLES - 1);

	// Register port map.
	localparam logic [ADDR_W-1:0] REG_STATUS_WORD = 4'h0;
	localparam logic [ADDR_W-1:0] REG_LAST_TARGET = 4'h1;
	localparam logic [ADDR_W-1:0] REG_EXEC_STATE  = 4'h2;

	// Flag bit positions inside the status word.
	localparam int unsigned FLAG_C_POS  = 0;
	localparam int unsigned FLAG_Z_POS  = 1;
	localparam int unsigned FLAG_OVERFLOW_POS    = 2;
	localparam int unsigned FLAG_N_POS           = 3;
	localparam int unsigned FLAG_DIGIT_CARRY_POS = 8;

	// Values after reset.
	localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] TARGET_RESET = 16'h0000;

	typedef enum logic [2:0] {
		CBB_OP_NONE   = 3'b000,
		CBB_OP_BORROW = 3'b001,
		CBB_OP_BEQ    = 3'b010,
		CBB_OP_BGT    = 3'b011,
		CBB_OP_BLT    = 3'b100
	} cbb_op_e;

	typedef struct packed {
		cbb_op_e              op;
		logic [REG_IDX_W-1:0] base_sel;
		logic                 byte_mode;
		logic [2:0]           src_mode;
		logic [5:0]           offset;
		logic [REG_IDX_W-1:0] src_sel;
	} cbb_decode_s;

	typedef struct packed {
		logic digit_carry_flag;
		logic negative;
		logic overflow_flag;
		logic zero;
		logic carry;
	} cbb_flags_s;

	typedef struct packed {
		logic                 valid;
		logic [REG_IDX_W-1:0] sel;
		logic [DATA_W-1:0]    value;
	} cbb_ptr_wb_s;

endpackage : cbb_pkg

//--- compare_borrow_branch_exec_tb.sv
// Self-checking testbench for the compare and compare-branch execute block.
`timescale 1ns/10ps
`default_nettype none
module compare_borrow_branch_exec_tb
	import cbb_pkg::*;
;
	logic			clock = 1'b0;
	logic			nrst = 1'b0;
	logic			clock_en = 1'b1;
	logic			instr_valid = 1'b0;
	logic [23:0]	instr_word = 24'h000000;
	logic [15:0]	instr_addr = 16'h2000;
	logic [15:0]	base_operand_reg = 16'h0000;
	logic [15:0]	source_operand_reg = 16'h0000;
	logic [15:0]	second_operand_reg = 16'h0000;
	logic [15:0]	src_pointer = 16'h1000;
	logic [3:0]		reg_addr = 4'h0;
	logic [15:0]	reg_wdata = 16'h0000;
	logic			reg_write = 1'b0;
	logic			reg_read = 1'b0;
	logic [15:0]	reg_rdata;
	logic [15:0]	status_word;
	logic			busy;
	logic			claimed;
	logic			pc_load;
	logic [15:0]	pc_target;
	logic			flush_prefetch;
	logic			nop_issue;
	cbb_ptr_wb_s	ptr_wb;
	logic [15:0]	kept = 16'h0005;
	int				fails = 0;
	int				checks_done = 0;
	int				cycles = 0;

	cbb_exec i_cbb_exec (.clock, .nrst, .clock_en, .instr_valid, .instr_word, .instr_addr,
		.base_operand_reg, .source_operand_reg, .second_operand_reg, .src_pointer, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .status_word, .busy, .claimed, .pc_load,
		.pc_target, .flush_prefetch, .nop_issue, .ptr_wb);

	always #50 clock = ~clock;

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up

	// The whole run needs about 130 cycles; a hang is stopped by this watchdog at cycle 2000.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fails++;
			wrap_up();
		end
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, e);
		@(posedge clock);
	endtask : rd

	function automatic logic [23:0] bw(input logic [8:0] o, input logic b, input logic [5:0] n);
		return {o, 4'h0, b, n, 4'h1};
	endfunction : bw

	function automatic logic [23:0] cw(input logic b, input logic [2:0] p);
		return {OPC_COMPARE_WITH_BORROW, 4'h0, b, 3'h0, p, 4'h1};
	endfunction : cw

	// Flags f are claimed, pc_load, flush, no-op and pointer valid; status is read two edges on.
	task automatic ex(input logic [23:0] w, input logic [15:0] a, input logic [15:0] b,
		input logic [4:0] f, input logic [15:0] t, input logic [15:0] st);
		instr_word <= w;
		base_operand_reg <= a;
		second_operand_reg <= b;
		source_operand_reg <= b;
		instr_valid <= 1'b1;
		@(posedge clock);
		instr_valid <= 1'b0;
		#1;
		chk(16'({claimed, pc_load, flush_prefetch, nop_issue, ptr_wb.valid}), 16'(f));
		chk(16'(busy), 16'(f[3]));
		if (f[3]) chk(pc_target, t);
		if (f[0]) chk(ptr_wb.value, t);
		if (f[0]) chk(16'(ptr_wb.sel), 16'h0001);
		@(posedge clock);
		#1;
		chk(status_word, st);
		repeat (4) @(posedge clock);
	endtask : ex

	initial begin
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		rd(REG_STATUS_WORD, STATUS_RESET);
		rd(REG_LAST_TARGET, TARGET_RESET);
		rd(4'hF, 16'h0000);
		wr(REG_STATUS_WORD, 16'hFFFF);
		rd(REG_STATUS_WORD, 16'h010F);
		wr(REG_LAST_TARGET, 16'h1234);
		rd(REG_LAST_TARGET, TARGET_RESET);
		wr(REG_STATUS_WORD, 16'h0002);
		ex(cw(1'b1, MODE_POST_INC), 16'hABA9, 16'hD0A9, 5'b10001, 16'h1001, 16'h0008);
		wr(REG_STATUS_WORD, 16'h0001);
		ex(cw(1'b0, MODE_DIRECT), 16'h3000, 16'h3000, 5'b10000, 16'h0000, 16'h0101);
		wr(REG_STATUS_WORD, 16'h0003);
		ex(cw(1'b0, MODE_DIRECT), 16'h3000, 16'h3000, 5'b10000, 16'h0000, 16'h0103);
		wr(REG_STATUS_WORD, 16'h0001);
		ex(cw(1'b0, MODE_INDIRECT), 16'h8000, 16'h0001, 5'b10000, 16'h0000, kept);
		ex(bw(OPC_BRANCH_EQUAL, 1'b0, 6'h03), 16'h1000, 16'h1000, 5'b11110, 16'h2008, kept);
		ex(bw(OPC_BRANCH_EQUAL, 1'b0, 6'h03), 16'h1000, 16'h1001, 5'b10000, 16'h0000, kept);
		ex(bw(OPC_BRANCH_GREATER, 1'b1, 6'h03), 16'h30FF, 16'h26FE, 5'b11110, 16'h2008, kept);
		ex(bw(OPC_BRANCH_GREATER, 1'b0, 6'h20), 16'h8000, 16'h0001, 5'b10000, 16'h0000, kept);
		ex(bw(OPC_BRANCH_GREATER, 1'b0, 6'h20), 16'h1234, 16'h1234, 5'b10000, 16'h0000, kept);
		ex(bw(OPC_BRANCH_LESS, 1'b1, 6'h03), 16'h00FF, 16'h26FE, 5'b10000, 16'h0000, kept);
		ex(bw(OPC_BRANCH_LESS, 1'b0, 6'h3F), 16'h8000, 16'h0001, 5'b11110, 16'h2000, kept);
		ex(bw(OPC_BRANCH_GREATER, 1'b0, 6'h20), 16'h7FFF, 16'h8000, 5'b11110, 16'h1FC2, kept);
		ex({9'h1CE, 15'h0000}, 16'h1000, 16'h1000, 5'b00000, 16'h0000, kept);
		rd(REG_LAST_TARGET, 16'h1FC2);
		// A word still offered during the stall of a taken branch must be refused.
		instr_word <= bw(OPC_BRANCH_EQUAL, 1'b0, 6'h01);
		base_operand_reg <= 16'h0042;
		second_operand_reg <= 16'h0042;
		instr_valid <= 1'b1;
		@(posedge clock);
		reg_addr <= REG_EXEC_STATE;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		instr_valid <= 1'b0;
		#1;
		chk(reg_rdata, 16'(STALL_AFTER_TAKEN));
		chk(16'({claimed, busy}), 16'h0001);
		repeat (4) @(posedge clock);
		// With the enable low a compare-with-borrow must leave no trace at all.
		clock_en <= 1'b0;
		instr_word <= cw(1'b0, MODE_POST_INC);
		base_operand_reg <= 16'h0000;
		source_operand_reg <= 16'h0001;
		instr_valid <= 1'b1;
		repeat (2) @(posedge clock);
		instr_valid <= 1'b0;
		clock_en <= 1'b1;
		#1;
		chk(16'({claimed, ptr_wb.valid}), 16'h0000);
		@(posedge clock);
		rd(REG_LAST_TARGET, 16'h2004);
		rd(REG_STATUS_WORD, kept);
		wrap_up();
	end
endmodule : compare_borrow_branch_exec_tb
`default_nettype wire
